// file: pbcap_pkg.sv
/*
 * shared constants of the power budget capability register bank:
 * byte offsets, field positions, reset values and fixed encodings.
 * assumes a 32-bit register bus with one aligned word per register.
 */
package pbcap_pkg;

  // byte offsets
  localparam logic [11:0] PBCAP_OFF_HDR   = 12'h20c;
  localparam logic [11:0] PBCAP_OFF_SEL   = 12'h210;
  localparam logic [11:0] PBCAP_OFF_DATA  = 12'h214;
  localparam logic [11:0] PBCAP_OFF_ALLOC = 12'h218;

  // header fields
  localparam int          PBCAP_HDR_ID_LSB   = 0;
  localparam int          PBCAP_HDR_VER_LSB  = 16;
  localparam int          PBCAP_HDR_NEXT_LSB = 20;
  localparam logic [15:0] PBCAP_CAP_ID       = 16'h0004;
  localparam logic [3:0]  PBCAP_CAP_VER      = 4'h1;
  localparam logic [11:0] PBCAP_NEXT_UP      = 12'h230;
  localparam logic [11:0] PBCAP_NEXT_DOWN    = 12'h220;

  // selector
  localparam logic [7:0]  PBCAP_SEL_RST  = 8'h00;
  localparam logic [7:0]  PBCAP_SEL_MAX  = 8'h00;
  localparam logic [7:0]  PBCAP_SEL_SUST = 8'h01;

  // data register fields
  localparam int          PBCAP_DAT_BASE_LSB  = 0;
  localparam int          PBCAP_DAT_SCALE_LSB = 8;
  localparam int          PBCAP_DAT_SUB_LSB   = 10;
  localparam int          PBCAP_DAT_STATE_LSB = 13;
  localparam int          PBCAP_DAT_TYPE_LSB  = 15;
  localparam int          PBCAP_DAT_RAIL_LSB  = 18;
  localparam int          PBCAP_ENTRY_W       = 21;
  localparam logic [7:0]  PBCAP_BASE_RST      = 8'h04;
  localparam logic [1:0]  PBCAP_SCALE_RST     = 2'h0;
  localparam logic [2:0]  PBCAP_SUB_RST       = 3'h0;
  localparam logic [1:0]  PBCAP_STATE_FULL    = 2'h0;
  localparam logic [2:0]  PBCAP_TYPE_MAX      = 3'h7;
  localparam logic [2:0]  PBCAP_TYPE_SUST     = 3'h0;
  localparam logic [2:0]  PBCAP_RAIL_RST      = 3'h2;

  // allocation register
  localparam int          PBCAP_ALLOC_LSB = 0;
  localparam logic        PBCAP_ALLOC_RST = 1'b0;

  // ahb encodings
  localparam logic [1:0]  PBCAP_HTRANS_NSEQ = 2'h2;
  localparam logic        PBCAP_HRESP_OKAY  = 1'b0;

endpackage

// file: pbcap_ahb_front.sv
/*
 * ahb-lite address phase capture: registers the address of an
 * accepted transfer and flags the first data phase cycle.
 * assumes single word transfers and a slave that inserts wait
 * states only on reads.
 */
`timescale 1ns/1ps
`default_nettype none
module pbcap_ahb_front #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // address phase
  input  wire logic              hsel_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic              hready_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  // data phase flags
  output logic                   wr_pend_o,
  output logic                   rd_pend_o,
  output logic [ADDR_W-1:0]      addr_o
);
  import pbcap_pkg::*;

  wire              take     = hsel_i & htrans_i[1] & hready_i;
  wire [ADDR_W-1:0] addr_nxt = take ? haddr_i : addr_o;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_o <= 1'b0;
      rd_pend_o <= 1'b0;
      addr_o    <= '0;
    end else begin
      wr_pend_o <= take & hwrite_i;
      rd_pend_o <= take & ~hwrite_i;
      addr_o    <= addr_nxt;
    end
  end
endmodule
`default_nettype wire

// file: pbcap_entry_tbl.sv
/*
 * power budget entry table: two supported entries, zero for any
 * other index; the selected entry comes out of a register.
 * assumes the index and base power are given as next-cycle values.
 */
`timescale 1ns/1ps
`default_nettype none
module pbcap_entry_tbl #(
  parameter logic [7:0] SUST_BASE = 8'h04
) (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_n_i,
  // selection
  input  wire logic [7:0]                         sel_i,
  input  wire logic [7:0]                         max_base_i,
  // registered entry
  output logic [pbcap_pkg::PBCAP_ENTRY_W-1:0]     entry_o
);
  import pbcap_pkg::*;

  localparam logic [PBCAP_ENTRY_W-1:0] ENTRY_RST = {PBCAP_RAIL_RST, PBCAP_TYPE_MAX,
    PBCAP_STATE_FULL, PBCAP_SUB_RST, PBCAP_SCALE_RST, PBCAP_BASE_RST};

  function automatic logic [PBCAP_ENTRY_W-1:0] pack_entry(
    input logic [7:0] base,
    input logic [2:0] typ
  );
    pack_entry = {PBCAP_RAIL_RST, typ, PBCAP_STATE_FULL, PBCAP_SUB_RST,
                  PBCAP_SCALE_RST, base};
  endfunction

  wire [PBCAP_ENTRY_W-1:0] max_ent  = pack_entry(max_base_i, PBCAP_TYPE_MAX);
  wire [PBCAP_ENTRY_W-1:0] sust_ent = pack_entry(SUST_BASE, PBCAP_TYPE_SUST);
  wire [PBCAP_ENTRY_W-1:0] ent_next = (sel_i == PBCAP_SEL_MAX)  ? max_ent  :
                                      (sel_i == PBCAP_SEL_SUST) ? sust_ent :
                                      '0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_o <= ENTRY_RST;
    end else begin
      entry_o <= ent_next;
    end
  end
endmodule
`default_nettype wire

// file: pbcap_top.sv
/*
 * power budget capability register bank behind an ahb-lite slave.
 * holds the capability header, the entry selector, the selected
 * entry's data word and the system allocation flag.
 * assumes one master, word transfers only, and an autoload engine
 * that presents loaded values with one-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module pbcap_top #(
  parameter int         ADDR_W    = 12,
  parameter logic [7:0] SUST_BASE = 8'h04
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RESET_N_I,
  // ahb-lite slave
  input  wire logic              HSEL_I,
  input  wire logic [ADDR_W-1:0] HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic              HREADY_I,
  input  wire logic [31:0]       HWDATA_I,
  output logic      [31:0]       HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  // port role strap
  input  wire logic              PORT_UPSTREAM_I,
  // nonvolatile autoload
  input  wire logic              ALOAD_BASE_VLD_I,
  input  wire logic [7:0]        ALOAD_BASE_I,
  input  wire logic              ALOAD_ALLOC_VLD_I,
  input  wire logic              ALOAD_ALLOC_I
);
  import pbcap_pkg::*;

  logic                     wr_pend;
  logic                     rd_pend;
  logic [ADDR_W-1:0]        addr_q;
  logic [PBCAP_ENTRY_W-1:0] entry_q;

  logic [7:0]  sel_reg;
  logic [7:0]  max_base_reg;
  logic        alloc_reg;
  logic        up_reg;
  logic        strap_done_reg;
  logic [31:0] hrdata_reg;
  logic        hready_reg;
  logic        hresp_reg;

  // address phase capture
  pbcap_ahb_front #(
    .ADDR_W    (ADDR_W)
  ) u_front (
    .clk_i     (CLK_I),
    .rst_n_i   (RESET_N_I),
    .hsel_i    (HSEL_I),
    .htrans_i  (HTRANS_I),
    .hwrite_i  (HWRITE_I),
    .hready_i  (HREADY_I),
    .haddr_i   (HADDR_I),
    .wr_pend_o (wr_pend),
    .rd_pend_o (rd_pend),
    .addr_o    (addr_q)
  );

  // decode of the data phase address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  wire hit_hdr   = hit(addr_q, PBCAP_OFF_HDR);
  wire hit_sel   = hit(addr_q, PBCAP_OFF_SEL);
  wire hit_data  = hit(addr_q, PBCAP_OFF_DATA);
  wire hit_alloc = hit(addr_q, PBCAP_OFF_ALLOC);
  wire hit_none  = ~(hit_hdr | hit_sel | hit_data | hit_alloc);

  // only the selector byte is writable
  wire       wr_sel   = wr_pend & hit_sel;
  wire [7:0] sel_next = wr_sel ? HWDATA_I[7:0] : sel_reg;

  // autoload overrides
  wire [7:0] max_base_next = ALOAD_BASE_VLD_I ? ALOAD_BASE_I : max_base_reg;
  wire       alloc_next    = ALOAD_ALLOC_VLD_I ? ALOAD_ALLOC_I : alloc_reg;

  // strap caught once after reset release
  wire up_next = strap_done_reg ? up_reg : PORT_UPSTREAM_I;

  // entry table, fed with next values so reads see fresh data
  pbcap_entry_tbl #(
    .SUST_BASE  (SUST_BASE)
  ) u_tbl (
    .clk_i      (CLK_I),
    .rst_n_i    (RESET_N_I),
    .sel_i      (sel_next),
    .max_base_i (max_base_next),
    .entry_o    (entry_q)
  );

  // read words
  wire [11:0] next_ptr = up_reg ? PBCAP_NEXT_UP : PBCAP_NEXT_DOWN;
  wire [31:0] hdr_word = {next_ptr, PBCAP_CAP_VER, PBCAP_CAP_ID};
  wire [31:0] sel_word = {24'h000000, sel_reg};
  wire [31:0] dat_word = {11'h000, entry_q};
  wire [31:0] alc_word = {31'h00000000, alloc_reg};

  wire [31:0] rd_word = hit_hdr   ? hdr_word :
                        hit_sel   ? sel_word :
                        hit_data  ? dat_word :
                        hit_alloc ? alc_word :
                        32'h00000000;

  // reads take one wait state, writes none
  wire take_rd     = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
  wire hready_next = ~take_rd;
  wire [31:0] hrdata_next = rd_pend ? rd_word : hrdata_reg;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sel_reg <= PBCAP_SEL_RST;
    end else begin
      sel_reg <= sel_next;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      max_base_reg <= PBCAP_BASE_RST;
      alloc_reg    <= PBCAP_ALLOC_RST;
    end else begin
      max_base_reg <= max_base_next;
      alloc_reg    <= alloc_next;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      up_reg         <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      up_reg         <= up_next;
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hrdata_reg <= 32'h00000000;
      hready_reg <= 1'b1;
      hresp_reg  <= PBCAP_HRESP_OKAY;
    end else begin
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
      hresp_reg  <= PBCAP_HRESP_OKAY;
    end
  end

  assign HRDATA_O    = hrdata_reg;
  assign HREADYOUT_O = hready_reg;
  assign HRESP_O     = hresp_reg;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_rd_hdr;
    rd_pend && hit_hdr;
  endsequence

  sequence s_rd_data(logic [7:0] idx);
    rd_pend && hit_data && (sel_reg == idx);
  endsequence

  sequence s_rd_accept;
    take_rd;
  endsequence

  sequence s_rd_finish;
    !HREADYOUT_O ##1 HREADYOUT_O;
  endsequence

  sequence s_sel_wr_rd;
    wr_sel ##1 !wr_sel ##1 (rd_pend && hit_sel);
  endsequence

  sequence s_rd_unmapped;
    rd_pend && hit_none;
  endsequence

  AST_HDR_ID: assert property (s_rd_hdr |=> HRDATA_O[15:0] == 16'h0004)
    else $error("header id field wrong");

  AST_HDR_VER: assert property (s_rd_hdr |=> HRDATA_O[19:16] == 4'h1)
    else $error("header version field wrong");

  AST_HDR_NEXT: assert property (s_rd_hdr |=>
    HRDATA_O[31:20] == ($past(up_reg) ? 12'h230 : 12'h220))
    else $error("next pointer does not match port role");

  AST_SEL_WR: assert property (s_sel_wr_rd |=>
    HRDATA_O == {24'h000000, $past(HWDATA_I[7:0], 3)})
    else $error("selector write not read back");

  AST_DATA_MAX: assert property (s_rd_data(8'h00) |=>
    HRDATA_O[17:15] == 3'h7 && HRDATA_O[7:0] == $past(max_base_reg))
    else $error("max entry wrong");

  AST_DATA_FIXED: assert property (s_rd_data(8'h00) |=>
    HRDATA_O[9:8] == 2'h0 && HRDATA_O[12:10] == 3'h0 &&
    HRDATA_O[14:13] == 2'h0 && HRDATA_O[20:18] == 3'h2 &&
    HRDATA_O[31:21] == 11'h000)
    else $error("fixed entry fields wrong");

  AST_DATA_SUST: assert property (s_rd_data(8'h01) |=>
    HRDATA_O[17:15] == 3'h0 && HRDATA_O[7:0] == SUST_BASE)
    else $error("sustained entry wrong");

  AST_DATA_ZERO: assert property (rd_pend && hit_data && sel_reg > 8'h01 |=>
    HRDATA_O == 32'h00000000)
    else $error("unsupported index not zero");

  AST_ALOAD_BASE: assert property (ALOAD_BASE_VLD_I |=>
    max_base_reg == $past(ALOAD_BASE_I))
    else $error("autoload base power not taken");

  AST_ALOAD_ALLOC: assert property (ALOAD_ALLOC_VLD_I |=>
    alloc_reg == $past(ALOAD_ALLOC_I))
    else $error("autoload allocation flag not taken");

  AST_ALLOC_RD: assert property (rd_pend && hit_alloc |=>
    HRDATA_O[31:1] == 31'h00000000 && HRDATA_O[0] == $past(alloc_reg))
    else $error("allocation register read wrong");

  AST_RO_KEEP: assert property (wr_pend && !hit_sel |=>
    sel_reg == $past(sel_reg) &&
    ($past(ALOAD_BASE_VLD_I) || max_base_reg == $past(max_base_reg)) &&
    ($past(ALOAD_ALLOC_VLD_I) || alloc_reg == $past(alloc_reg)))
    else $error("write to read-only word changed state");

  AST_RD_WAIT: assert property (s_rd_accept |=> s_rd_finish)
    else $error("read wait state missing");

  AST_WR_NOWAIT: assert property (wr_pend |-> HREADYOUT_O)
    else $error("write data phase stalled");

  AST_HREADY_LOW: assert property (!HREADYOUT_O |=> HREADYOUT_O)
    else $error("ready held low for more than one cycle");

  AST_HRDATA_HOLD: assert property (!rd_pend |=>
    HRDATA_O == $past(HRDATA_O))
    else $error("read data changed without a read");

  AST_WR_SEL: assert property (wr_sel |=>
    sel_reg == $past(HWDATA_I[7:0]))
    else $error("selector write not taken");

  AST_SEL_HOLD: assert property (!wr_sel |=> sel_reg == $past(sel_reg))
    else $error("selector changed without a write");

  AST_SEL_UPPER: assert property (rd_pend && hit_sel |=>
    HRDATA_O[31:8] == 24'h000000)
    else $error("selector reserved bits not zero");

  AST_BASE_HOLD: assert property (!ALOAD_BASE_VLD_I |=>
    max_base_reg == $past(max_base_reg))
    else $error("base power changed without autoload");

  AST_ALLOC_HOLD: assert property (!ALOAD_ALLOC_VLD_I |=>
    alloc_reg == $past(alloc_reg))
    else $error("allocation flag changed without autoload");

  AST_STRAP_HOLD: assert property (strap_done_reg |=> up_reg == $past(up_reg))
    else $error("port role changed after capture");

  AST_DATA_RSVD: assert property (rd_pend && hit_data |=>
    HRDATA_O[31:21] == 11'h000)
    else $error("data reserved bits not zero");

  AST_SUST_FIXED: assert property (s_rd_data(8'h01) |=>
    HRDATA_O[9:8] == 2'h0 && HRDATA_O[12:10] == 3'h0 &&
    HRDATA_O[14:13] == 2'h0 && HRDATA_O[20:18] == 3'h2)
    else $error("fixed sustained entry fields wrong");

  AST_UNMAPPED: assert property (s_rd_unmapped |=> HRDATA_O == 32'h00000000)
    else $error("unmapped address not read as zero");

endmodule
`default_nettype wire

// file: pbcap_tb.sv
/*
 * self-checking bench for the power budget capability register bank.
 * assumes the bus master below is the only master and that the
 * bank answers writes at once and reads after one wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pbcap_pkg::*;

  localparam logic [7:0] SUST_B = 8'h09;

  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        upstream;
  logic        base_vld;
  logic [7:0]  base_val;
  logic        alloc_vld;
  logic        alloc_val;
  int          err_total;
  int          checks_done;
  logic [31:0] rd;

  pbcap_top #(.ADDR_W(12), .SUST_BASE(SUST_B)) u_pbcap_top (
    .CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hreadyout),
    .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .PORT_UPSTREAM_I(upstream), .ALOAD_BASE_VLD_I(base_vld), .ALOAD_BASE_I(base_val),
    .ALOAD_ALLOC_VLD_I(alloc_vld), .ALOAD_ALLOC_I(alloc_val));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected data word for an entry
  function automatic logic [31:0] entry(input logic [7:0] base, input logic [2:0] typ);
    return {11'h0, PBCAP_RAIL_RST, typ, PBCAP_STATE_FULL, PBCAP_SUB_RST, PBCAP_SCALE_RST, base};
  endfunction

  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] r);
    int waits;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= PBCAP_HTRANS_NSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    waits = 0;
    do begin
      @(posedge clk);
      waits++;
    end while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, PBCAP_HRESP_OKAY});
    chk(32'(waits), wr ? 32'h1 : 32'h2);
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'b1, d, dummy);
  endtask

  task automatic rd32(input logic [11:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h0, r);
  endtask

  task automatic do_reset(input logic up);
    @(posedge clk);
    rst_n    <= 1'b0;
    upstream <= up;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset_values;
    rd32(PBCAP_OFF_HDR, rd);
    chk(rd, {PBCAP_NEXT_DOWN, 4'h1, 16'h0004});
    rd32(PBCAP_OFF_SEL, rd);
    chk(rd, 32'h0);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, {11'h0, 3'h2, 3'h7, 2'h0, 3'h0, 2'h0, 8'h04});
    rd32(PBCAP_OFF_ALLOC, rd);
    chk(rd, 32'h0);
  endtask

  task automatic t_readonly_writes;
    wr32(PBCAP_OFF_HDR, 32'hffff_ffff);
    rd32(PBCAP_OFF_HDR, rd);
    chk(rd, {PBCAP_NEXT_DOWN, 4'h1, 16'h0004});
    wr32(PBCAP_OFF_DATA, 32'hffff_ffff);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(8'h04, 3'h7));
    wr32(PBCAP_OFF_ALLOC, 32'hffff_ffff);
    rd32(PBCAP_OFF_ALLOC, rd);
    chk(rd, 32'h0);
    wr32(12'h21c, 32'hffff_ffff);
    rd32(12'h21c, rd);
    chk(rd, 32'h0);
  endtask

  task automatic t_selector;
    wr32(PBCAP_OFF_SEL, 32'hffff_ff01);
    rd32(PBCAP_OFF_SEL, rd);
    chk(rd, 32'h0000_0001);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(SUST_B, 3'h0));
    wr32(PBCAP_OFF_SEL, 32'h0000_0002);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, 32'h0);
    wr32(PBCAP_OFF_SEL, 32'h0000_0080);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, 32'h0);
    wr32(PBCAP_OFF_SEL, 32'h0000_00ff);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, 32'h0);
    wr32(PBCAP_OFF_SEL, 32'h0000_0000);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(8'h04, 3'h7));
  endtask

  task automatic t_autoload;
    @(posedge clk);
    base_vld  <= 1'b1;
    base_val  <= 8'h5a;
    alloc_vld <= 1'b1;
    alloc_val <= 1'b1;
    @(posedge clk);
    base_vld  <= 1'b0;
    base_val  <= 8'ha5;
    alloc_vld <= 1'b0;
    alloc_val <= 1'b0;
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(8'h5a, 3'h7));
    rd32(PBCAP_OFF_ALLOC, rd);
    chk(rd, 32'h1);
    wr32(PBCAP_OFF_SEL, 32'h1);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(SUST_B, 3'h0));
  endtask

  task automatic t_upstream;
    do_reset(1'b1);
    rd32(PBCAP_OFF_HDR, rd);
    chk(rd, {PBCAP_NEXT_UP, 4'h1, 16'h0004});
    rd32(PBCAP_OFF_ALLOC, rd);
    chk(rd, 32'h0);
    rd32(PBCAP_OFF_DATA, rd);
    chk(rd, entry(8'h04, 3'h7));
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rst_n       = 1'b0;
    hsel        = 1'b0;
    haddr       = 12'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    upstream    = 1'b0;
    base_vld    = 1'b0;
    base_val    = 8'h0;
    alloc_vld   = 1'b0;
    alloc_val   = 1'b0;
    err_total   = 0;
    checks_done = 0;
    do_reset(1'b0);
    t_reset_values();
    t_readonly_writes();
    t_selector();
    t_autoload();
    t_upstream();
    report_and_stop();
  end

  // cut a hang short
  initial begin
    #(8 * 5000);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
